// ### include/rtctk_pkg.sv
/*
 Constants of the real time clock timekeeping block: SFR offsets,
 configuration bit positions, reset values and tick timing.
 Assumes an 8-bit SFR port and a crystal near 32 kHz.
*/
// What this block does
// - Fraction counter advances every 1/128 s from the crystal clock.
// - Fraction wraps 127 to 00 and increments seconds.
// - Seconds wrap 59 to 00 and increment minutes.
// - Minutes wrap 59 to 00 and increment hours.
// - With day-wrap select set, hours wrap 23 to 00.
// - With day-wrap select clear, hours wrap 255 to 00.
// - Every hour wrap sets the day-rollover flag and raises an interrupt.
// - Time counters survive soft resets; only power-on reset clears them.
// - Interval count equal to alarm value sets alarm flag and interrupt.
// - Interval counter is 8 bits, up to 256 units (alarm value 0).
// - An 8-bit software register holds the nominal trim value.
// - Trim register clears on every kind of reset.
// - Two-bit timebase picks 1/128 s, seconds, minutes or hours.
// - Single-shot clear restarts intervals; set gives one alarm only.
// - Timer disabled holds its counter at zero.
package rtctk_pkg;
    localparam logic [7:0] OFF_CFG      = 8'ha1;
    localparam logic [7:0] OFF_FRAC     = 8'ha2;
    localparam logic [7:0] OFF_SEC      = 8'ha3;
    localparam logic [7:0] OFF_MIN      = 8'ha4;
    localparam logic [7:0] OFF_HOUR     = 8'ha5;
    localparam logic [7:0] OFF_ALARM    = 8'ha6;
    localparam logic [7:0] OFF_TRIM     = 8'hf6;

    localparam int CFG_MIDNIGHT = 7;
    localparam int CFG_DAYWRAP  = 6;
    localparam int CFG_BASE_HI  = 5;
    localparam int CFG_BASE_LO  = 4;
    localparam int CFG_SINGLE   = 3;
    localparam int CFG_ALARM    = 2;
    localparam int CFG_TIMER_ON = 1;
    localparam int CFG_RTC_ON   = 0;

    localparam logic [7:0] RST_VAL      = 8'h00;
    localparam logic [7:0] FRAC_MAX     = 8'h7f;
    localparam logic [7:0] SEC_MAX      = 8'h3b;
    localparam logic [7:0] MIN_MAX      = 8'h3b;
    localparam logic [7:0] HOUR_MAX_24  = 8'h17;
    localparam logic [7:0] HOUR_MAX_256 = 8'hff;

    localparam int XTAL_HZ = 32768;
    localparam int TICK_HZ = 128;
    localparam int EDGES_PER_TICK = XTAL_HZ / TICK_HZ;

    typedef enum logic [1:0] {
        RTCTK_BASE_FRAC,
        RTCTK_BASE_SEC,
        RTCTK_BASE_MIN,
        RTCTK_BASE_HOUR
    } rtctk_base_t;
endpackage

// ### include/rtctk_evt_if.sv
/*
 Carrier of ticks, rollover events and interval timer settings
 between the timekeeping core, the tick generator and the interval timer.
 Assumes all three run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface rtctk_evt_if;
    logic                tick;
    logic                frac_zero;
    logic [7:0]          trim;
    logic                sec_evt;
    logic                min_evt;
    logic                hour_evt;
    logic                it_on;
    rtctk_pkg::rtctk_base_t it_base;
    logic                it_single;
    logic [7:0]          it_value;
    logic                alarm_hit;

    modport gen   (input trim, input frac_zero, output tick);
    modport timer (input tick, input sec_evt, input min_evt, input hour_evt,
                   input it_on, input it_base, input it_single, input it_value,
                   output alarm_hit);
    modport core  (input tick, input alarm_hit, output frac_zero, output trim,
                   output sec_evt, output min_evt, output hour_evt,
                   output it_on, output it_base, output it_single, output it_value);
endinterface
`default_nettype wire

// ### verilog/rtctk_tick_gen.sv
/*
 Divides the synchronised crystal clock into the 1/128 s tick,
 stretching or shortening one tick per second by the trim value.
 Assumes the crystal input is asynchronous to clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module rtctk_tick_gen #(
    parameter int EDGES = rtctk_pkg::EDGES_PER_TICK
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic xtal_in,
    rtctk_evt_if.gen  evt
);
    if (EDGES < 130 || EDGES > 800) begin : g_chk
        $error("EDGES out of range for trim arithmetic");
    end

    logic       xs1_r;
    logic       xs2_r;
    logic       xs3_r;
    logic       rise;
    logic [9:0] cnt_r;
    logic [9:0] target;
    logic       tick_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xs1_r <= 1'b0;
            xs2_r <= 1'b0;
            xs3_r <= 1'b0;
        end else begin
            xs1_r <= xtal_in;
            xs2_r <= xs1_r;
            xs3_r <= xs2_r;
        end
    end

    assign rise = xs2_r & ~xs3_r;

    // First tick of each second absorbs the signed trim
    always_comb begin
        target = 10'(EDGES - 1);
        if (evt.frac_zero) begin
            target = 10'(EDGES - 1) + {{2{evt.trim[7]}}, evt.trim};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r  <= 10'h000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= rise && (cnt_r >= target);
            if (rise) begin
                cnt_r <= (cnt_r >= target) ? 10'h000 : cnt_r + 10'h001;
            end
        end
    end

    assign evt.tick = tick_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    tick_one_a: assert property (tick_r |=> !tick_r)
        else $error("tick lasted more than one cycle");
endmodule
`default_nettype wire

// ### verilog/rtctk_interval.sv
/*
 Interval alarm timer: counts units of the selected timebase and
 pulses alarm_hit when the count reaches the alarm value.
 Assumes events from the core are one-cycle pulses on clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module rtctk_interval (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    input  wire logic  soft_rst_in,
    rtctk_evt_if.timer evt
);
    logic [7:0] cnt_r;
    logic       done_r;
    logic       hit_r;
    logic       unit;
    logic [7:0] cnt_inc;

    function automatic logic unit_sel(input rtctk_pkg::rtctk_base_t b,
                                      input logic t, input logic s,
                                      input logic m, input logic h);
        unique case (b)
            rtctk_pkg::RTCTK_BASE_FRAC: unit_sel = t;
            rtctk_pkg::RTCTK_BASE_SEC:  unit_sel = s;
            rtctk_pkg::RTCTK_BASE_MIN:  unit_sel = m;
            rtctk_pkg::RTCTK_BASE_HOUR: unit_sel = h;
        endcase
    endfunction

    assign unit    = unit_sel(evt.it_base, evt.tick, evt.sec_evt, evt.min_evt, evt.hour_evt);
    assign cnt_inc = cnt_r + 8'h01;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r  <= 8'h00;
            done_r <= 1'b0;
            hit_r  <= 1'b0;
        end else begin
            hit_r <= 1'b0;
            if (soft_rst_in || !evt.it_on) begin
                cnt_r  <= 8'h00;
                done_r <= 1'b0;
            end else if (unit && !done_r) begin
                if (cnt_inc == evt.it_value) begin
                    cnt_r  <= 8'h00;
                    done_r <= evt.it_single;
                    hit_r  <= 1'b1;
                end else begin
                    cnt_r <= cnt_inc;
                end
            end
        end
    end

    assign evt.alarm_hit = hit_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    held_off_a: assert property (!evt.it_on |=> cnt_r == 8'h00)
        else $error("interval counter moved while disabled");
    single_once_a: assert property (hit_r && $past(evt.it_single) && evt.it_on
                                    && !soft_rst_in |=> done_r)
        else $error("single-shot timer did not stop");
    hit_match_a: assert property (unit && !done_r && evt.it_on && !soft_rst_in
                                  && cnt_inc == evt.it_value |=> hit_r)
        else $error("alarm missed on count match");
endmodule
`default_nettype wire

// ### verilog/rtctk_top.sv
/*
 Timekeeping core: fraction, seconds, minutes and hours counters,
 configuration and trim registers on the SFR port, day rollover and
 alarm flags, and the pending interrupt pulse.
 Assumes SFR strobes are synchronous to clk_in; soft_rst_in is the
 watchdog or external reset, a synchronous level on clk_in.
*/
`timescale 1ns/10ps
`default_nettype none
module rtctk_top #(
    parameter int EDGES = rtctk_pkg::EDGES_PER_TICK
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       soft_rst_in,
    input  wire logic       xtal_in,
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            rtc_irq_out
);
    logic       rst_s1_r;
    logic       rst_n;
    logic [7:0] frac_r;
    logic [7:0] sec_r;
    logic [7:0] min_r;
    logic [7:0] hour_r;
    logic [7:0] alarm_val_r;
    logic [7:0] trim_r;
    logic       midnight_r;
    logic       day_wrap_r;
    logic [1:0] base_r;
    logic       single_r;
    logic       alarm_r;
    logic       timer_on_r;
    logic [7:0] rdata_nxt;
    logic [7:0] hour_max;
    logic       day_evt;
    logic       wr_cfg;
    logic       wr_frac;
    logic       wr_sec;
    logic       wr_min;
    logic       wr_hour;

    rtctk_evt_if evt ();

    // Power-on reset release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
        wr_hit = w && (a == off);
    endfunction

    function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] max);
        step = (v >= max) ? rtctk_pkg::RST_VAL : v + 8'h01;
    endfunction

    assign wr_cfg  = wr_hit(sfr_addr_in, rtctk_pkg::OFF_CFG, sfr_wr_in);
    assign wr_frac = wr_hit(sfr_addr_in, rtctk_pkg::OFF_FRAC, sfr_wr_in);
    assign wr_sec  = wr_hit(sfr_addr_in, rtctk_pkg::OFF_SEC, sfr_wr_in);
    assign wr_min  = wr_hit(sfr_addr_in, rtctk_pkg::OFF_MIN, sfr_wr_in);
    assign wr_hour = wr_hit(sfr_addr_in, rtctk_pkg::OFF_HOUR, sfr_wr_in);

    // Rollover cascade, each stage qualified by the one below
    assign hour_max      = day_wrap_r ? rtctk_pkg::HOUR_MAX_24
                                      : rtctk_pkg::HOUR_MAX_256;
    assign evt.sec_evt   = evt.tick && (frac_r >= rtctk_pkg::FRAC_MAX);
    assign evt.min_evt   = evt.sec_evt && (sec_r >= rtctk_pkg::SEC_MAX);
    assign evt.hour_evt  = evt.min_evt && (min_r >= rtctk_pkg::MIN_MAX);
    assign day_evt       = evt.hour_evt && (hour_r >= hour_max);
    assign evt.frac_zero = (frac_r == rtctk_pkg::RST_VAL);
    assign evt.trim      = trim_r;
    assign evt.it_on     = timer_on_r;
    assign evt.it_base   = rtctk_pkg::rtctk_base_t'(base_r);
    assign evt.it_single = single_r;
    assign evt.it_value  = alarm_val_r;

    rtctk_tick_gen #(
        .EDGES (EDGES)
    ) u_tick (
        .clk_in   (clk_in),
        .rst_n_in (rst_n),
        .xtal_in  (xtal_in),
        .evt      (evt)
    );

    rtctk_interval u_interval (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n),
        .soft_rst_in (soft_rst_in),
        .evt         (evt)
    );

    // Time counters ignore soft_rst_in; a write beats a tick in the same cycle
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            frac_r <= rtctk_pkg::RST_VAL;
        end else if (wr_frac) begin
            frac_r <= sfr_wdata_in;
        end else if (evt.tick) begin
            frac_r <= step(frac_r, rtctk_pkg::FRAC_MAX);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sec_r <= rtctk_pkg::RST_VAL;
        end else if (wr_sec) begin
            sec_r <= sfr_wdata_in;
        end else if (evt.sec_evt) begin
            sec_r <= step(sec_r, rtctk_pkg::SEC_MAX);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            min_r <= rtctk_pkg::RST_VAL;
        end else if (wr_min) begin
            min_r <= sfr_wdata_in;
        end else if (evt.min_evt) begin
            min_r <= step(min_r, rtctk_pkg::MIN_MAX);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            hour_r <= rtctk_pkg::RST_VAL;
        end else if (wr_hour) begin
            hour_r <= sfr_wdata_in;
        end else if (evt.hour_evt) begin
            hour_r <= step(hour_r, hour_max);
        end
    end

    // Day-wrap select survives soft reset; the other settings do not
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            day_wrap_r <= 1'b0;
        end else if (wr_cfg) begin
            day_wrap_r <= sfr_wdata_in[rtctk_pkg::CFG_DAYWRAP];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            base_r      <= 2'h0;
            single_r    <= 1'b0;
            timer_on_r  <= 1'b0;
            alarm_val_r <= rtctk_pkg::RST_VAL;
        end else if (soft_rst_in) begin
            base_r      <= 2'h0;
            single_r    <= 1'b0;
            timer_on_r  <= 1'b0;
            alarm_val_r <= rtctk_pkg::RST_VAL;
        end else begin
            if (wr_cfg) begin
                base_r     <= sfr_wdata_in[rtctk_pkg::CFG_BASE_HI:rtctk_pkg::CFG_BASE_LO];
                single_r   <= sfr_wdata_in[rtctk_pkg::CFG_SINGLE];
                timer_on_r <= sfr_wdata_in[rtctk_pkg::CFG_TIMER_ON];
            end
            if (wr_hit(sfr_addr_in, rtctk_pkg::OFF_ALARM, sfr_wr_in)) begin
                alarm_val_r <= sfr_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            trim_r <= rtctk_pkg::RST_VAL;
        end else if (soft_rst_in) begin
            trim_r <= rtctk_pkg::RST_VAL;
        end else if (wr_hit(sfr_addr_in, rtctk_pkg::OFF_TRIM, sfr_wr_in)) begin
            trim_r <= sfr_wdata_in;
        end
    end

    // Flags: writing 0 clears, writing 1 keeps; a new event wins over the clear
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            midnight_r <= 1'b0;
            alarm_r    <= 1'b0;
        end else if (soft_rst_in) begin
            midnight_r <= day_evt;
            alarm_r    <= evt.alarm_hit;
        end else begin
            midnight_r <= day_evt
                || (midnight_r && !(wr_cfg && !sfr_wdata_in[rtctk_pkg::CFG_MIDNIGHT]));
            alarm_r    <= evt.alarm_hit
                || (alarm_r && !(wr_cfg && !sfr_wdata_in[rtctk_pkg::CFG_ALARM]));
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rtc_irq_out <= 1'b0;
        end else begin
            rtc_irq_out <= day_evt || evt.alarm_hit;
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        unique case (sfr_addr_in)
            rtctk_pkg::OFF_CFG: begin
                rdata_nxt = {midnight_r, day_wrap_r, base_r, single_r,
                             alarm_r, timer_on_r, 1'b1};
            end
            rtctk_pkg::OFF_FRAC:  rdata_nxt = frac_r;
            rtctk_pkg::OFF_SEC:   rdata_nxt = sec_r;
            rtctk_pkg::OFF_MIN:   rdata_nxt = min_r;
            rtctk_pkg::OFF_HOUR:  rdata_nxt = hour_r;
            rtctk_pkg::OFF_ALARM: rdata_nxt = alarm_val_r;
            rtctk_pkg::OFF_TRIM:  rdata_nxt = trim_r;
            default:              rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sfr_rdata_out <= 8'h00;
        end else begin
            sfr_rdata_out <= rdata_nxt;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence frac_top_s;
        evt.tick && frac_r == 8'h7f && !wr_frac;
    endsequence

    sequence day_roll_s;
        evt.hour_evt && !wr_hour && hour_r == hour_max;
    endsequence

    frac_wrap_a: assert property (frac_top_s |=> frac_r == 8'h00)
        else $error("fraction did not wrap to zero");
    sec_carry_a: assert property (frac_top_s ##0 (sec_r == 8'h0a && !wr_sec)
                                  |=> sec_r == 8'h0b)
        else $error("fraction wrap did not advance seconds");
    sec_wrap_a: assert property (evt.sec_evt && sec_r == 8'h3b && !wr_sec
                                 |=> sec_r == 8'h00)
        else $error("seconds did not wrap at 59");
    min_wrap_a: assert property (evt.min_evt && min_r == 8'h3b && !wr_min
                                 |=> min_r == 8'h00)
        else $error("minutes did not wrap at 59");
    hour_24_a: assert property (day_wrap_r && evt.hour_evt && hour_r == 8'h17 && !wr_hour
                                |=> hour_r == 8'h00)
        else $error("hours did not wrap at 23");
    hour_256_a: assert property (!day_wrap_r && evt.hour_evt && hour_r == 8'h17 && !wr_hour
                                 |=> hour_r == 8'h18)
        else $error("hours wrapped early in 256-hour mode");
    midnight_irq_a: assert property (day_roll_s |=> midnight_r && rtc_irq_out)
        else $error("day rollover missed flag or interrupt");
    time_keep_a: assert property (soft_rst_in && !evt.tick && !wr_frac
                                  |=> $stable(frac_r))
        else $error("soft reset disturbed the fraction counter");
    trim_clear_a: assert property (soft_rst_in |=> trim_r == 8'h00 [*1])
        else $error("soft reset left trim value");
    alarm_flag_a: assert property (evt.alarm_hit |=> alarm_r && rtc_irq_out)
        else $error("alarm hit did not set flag and interrupt");

    sequence cfg_clear_s;
        wr_cfg && !sfr_wdata_in[rtctk_pkg::CFG_MIDNIGHT] && !day_evt;
    endsequence

    sequence trim_wr_s;
        wr_hit(sfr_addr_in, rtctk_pkg::OFF_TRIM, sfr_wr_in) && !soft_rst_in;
    endsequence

    sequence hour_step_s;
        evt.hour_evt && !wr_hour && hour_r < hour_max;
    endsequence

    midnight_clear_a: assert property (cfg_clear_s |=> !midnight_r)
        else $error("midnight flag not cleared by write");
    alarm_clear_a: assert property (wr_cfg && !sfr_wdata_in[rtctk_pkg::CFG_ALARM]
                                    && !evt.alarm_hit |=> !alarm_r)
        else $error("alarm flag not cleared by write");
    trim_load_a: assert property (trim_wr_s |=> trim_r == $past(sfr_wdata_in))
        else $error("trim write did not load");
    hour_step_a: assert property (hour_step_s |=> hour_r == $past(hour_r) + 8'h01)
        else $error("hour counter did not step by one");
    min_step_a: assert property (evt.min_evt && !wr_min && min_r < 8'h3b
                                 |=> min_r == $past(min_r) + 8'h01)
        else $error("minute counter did not step by one");
    sec_keep_a: assert property (soft_rst_in && !evt.sec_evt && !wr_sec |=> $stable(sec_r))
        else $error("soft reset disturbed the seconds counter");
    hour_keep_a: assert property (soft_rst_in && !evt.hour_evt && !wr_hour |=> $stable(hour_r))
        else $error("soft reset disturbed the hour counter");
    frac_read_a: assert property (sfr_addr_in == rtctk_pkg::OFF_FRAC |=> sfr_rdata_out == $past(frac_r))
        else $error("fraction read back wrong");
endmodule
`default_nettype wire

// ### verification/rtc_timekeeping_interval_alarm_bench.sv
/*
 Self-checking bench of the timekeeping top: cascade wraps, both hour modes,
 interval alarm timebases and shots, soft and power-on resets, register reads.
 Assumes the SFR port contract of the design and a crystal it may run fast.
*/
`timescale 1ns/10ps
`default_nettype none
module rtc_timekeeping_interval_alarm_bench;
    localparam int EDGES = 130;
    localparam int LIMIT = 90000;
    logic       clk_in       = 1'b0;
    logic       rst_n_in     = 1'b0;
    logic       soft_rst_in  = 1'b0;
    logic       xtal_in      = 1'b0;
    logic [7:0] sfr_addr_in  = 8'h00;
    logic       sfr_wr_in    = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [7:0] sfr_rdata_out;
    logic       rtc_irq_out;
    logic [7:0] rd_v;
    int         n_fail  = 0;
    int         n_tests = 0;
    int         n_irq   = 0;
    int         cycles  = 0;
    int         xdiv    = 0;
    int         seed    = 26;
    int         m_f, m_s, m_m, m_h, m_dw, m_mid, irq0, i, b, t0;
    int         tab [5][5] = '{'{1, 127, 59, 59, 23}, '{0, 127, 59, 59, 255}, '{0, 127, 59, 59, 23},
                               '{1, 127, 59, 12, 7}, '{1, 100, 20, 30, 4}};

    rtctk_top #(.EDGES(EDGES)) rtctk_top_i (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .soft_rst_in   (soft_rst_in),
        .xtal_in       (xtal_in),
        .sfr_addr_in   (sfr_addr_in),
        .sfr_wr_in     (sfr_wr_in),
        .sfr_wdata_in  (sfr_wdata_in),
        .sfr_rdata_out (sfr_rdata_out),
        .rtc_irq_out   (rtc_irq_out)
    );

    always #5 clk_in = ~clk_in;

    // Crystal sped up to a period of six clocks so ticks come quickly
    always @(negedge clk_in) begin
        xdiv <= (xdiv == 2) ? 0 : xdiv + 1;
        if (xdiv == 2) begin
            xtal_in <= ~xtal_in;
        end
    end

    always @(posedge clk_in) begin
        if (rtc_irq_out === 1'b1) begin
            n_irq <= n_irq + 1;
        end
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        sfr_addr_in  = a;
        sfr_wdata_in = d;
        sfr_wr_in    = 1'b1;
        @(negedge clk_in);
        sfr_wr_in    = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clk_in);
        sfr_addr_in = a;
        @(negedge clk_in);
        rd_v = sfr_rdata_out;
    endtask

    task automatic model_tick();
        m_f = m_f + 1;
        if (m_f > 127) begin
            m_f = 0;
            m_s++;
            if (m_s > 59) begin
                m_s = 0;
                m_m++;
                if (m_m > 59) begin
                    m_m = 0;
                    m_h++;
                    if ((m_dw == 1 && m_h > 23) || m_h > 255) begin
                        m_h   = 0;
                        m_mid = 1;
                    end
                end
            end
        end
    endtask

    // Polls the fraction register until it moves, then steps the model once
    task automatic wait_tick();
        int k;
        k = 0;
        rd(rtctk_pkg::OFF_FRAC);
        while (rd_v === 8'(m_f) && k < 2000) begin
            rd(rtctk_pkg::OFF_FRAC);
            k++;
        end
        model_tick();
        chk("fraction", 8'(m_f), rd_v);
    endtask

    task automatic check_time(input int cfg_low);
        rd(rtctk_pkg::OFF_SEC);
        chk("seconds", 8'(m_s), rd_v);
        rd(rtctk_pkg::OFF_MIN);
        chk("minutes", 8'(m_m), rd_v);
        rd(rtctk_pkg::OFF_HOUR);
        chk("hours", 8'(m_h), rd_v);
        rd(rtctk_pkg::OFF_CFG);
        chk("config", 8'(m_mid * 128 + m_dw * 64 + cfg_low), rd_v);
    endtask

    // Writes just after a tick so no tick lands among the writes
    task automatic set_time(input int dw, input int f, input int s, input int m, input int h);
        wait_tick();
        wr(rtctk_pkg::OFF_CFG, 8'(dw * 64));
        wr(rtctk_pkg::OFF_FRAC, 8'(f));
        wr(rtctk_pkg::OFF_SEC, 8'(s));
        wr(rtctk_pkg::OFF_MIN, 8'(m));
        wr(rtctk_pkg::OFF_HOUR, 8'(h));
        m_dw  = dw;
        m_f   = f;
        m_s   = s;
        m_m   = m;
        m_h   = h;
        m_mid = 0;
    endtask

    task automatic por_check();
        m_f   = 0;
        m_s   = 0;
        m_m   = 0;
        m_h   = 0;
        m_dw  = 0;
        m_mid = 0;
        rd(rtctk_pkg::OFF_FRAC);
        chk("fraction", 8'h00, rd_v);
        check_time(1);
        rd(rtctk_pkg::OFF_ALARM);
        chk("alarm value", 8'h00, rd_v);
        rd(rtctk_pkg::OFF_TRIM);
        chk("trim", 8'h00, rd_v);
        rd(8'h00);
        chk("unmapped", 8'h00, rd_v);
    endtask

    initial begin
        repeat (12) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (5) @(negedge clk_in);
        por_check();
        $display("test reset values done");
        for (i = 0; i < 5; i++) begin
            set_time(tab[i][0], tab[i][1], tab[i][2], tab[i][3], tab[i][4]);
            irq0 = n_irq;
            wait_tick();
            check_time(1);
            chk("hour wrap irq", 8'(m_mid), 8'(n_irq - irq0));
        end
        $display("test cascade done");
        repeat (4) begin
            set_time($unsigned($random(seed)) % 2, 120 + $unsigned($random(seed)) % 8,
                     $unsigned($random(seed)) % 60, $unsigned($random(seed)) % 60, $unsigned($random(seed)) % 24);
            repeat (3) wait_tick();
            check_time(1);
        end
        $display("test random time done");
        for (b = 0; b < 4; b++) begin
            set_time(1, 127, 59, 59, 5);
            wr(rtctk_pkg::OFF_ALARM, 8'h01);
            wr(rtctk_pkg::OFF_CFG, 8'(64 + b * 16 + 2));
            irq0 = n_irq;
            wait_tick();
            wait_tick();
            repeat (4) @(negedge clk_in);
            chk("alarm count", (b == 0) ? 8'h02 : 8'h01, 8'(n_irq - irq0));
            rd(rtctk_pkg::OFF_CFG);
            chk("alarm flag", 8'(64 + b * 16 + 7), rd_v);
            wr(rtctk_pkg::OFF_CFG, 8'(64 + b * 16 + 2));
            rd(rtctk_pkg::OFF_CFG);
            chk("alarm cleared", 8'(64 + b * 16 + 3), rd_v);
        end
        $display("test timebase done");
        for (i = 1; i >= 0; i--) begin
            set_time(1, 10, 0, 0, 0);
            wr(rtctk_pkg::OFF_ALARM, 8'h02);
            wr(rtctk_pkg::OFF_CFG, 8'(64 + i * 8 + 2));
            irq0 = n_irq;
            repeat (6) wait_tick();
            repeat (4) @(negedge clk_in);
            chk("shot count", (i == 1) ? 8'h01 : 8'h03, 8'(n_irq - irq0));
        end
        $display("test single shot done");
        wr(rtctk_pkg::OFF_TRIM, 8'h05);
        wr(rtctk_pkg::OFF_ALARM, 8'h07);
        rd(rtctk_pkg::OFF_TRIM);
        chk("trim", 8'h05, rd_v);
        wr(rtctk_pkg::OFF_FRAC, 8'h7f);
        m_f = 127;
        wait_tick();
        t0 = cycles;
        wait_tick();
        chk("trim period", 8'(EDGES + 5), 8'((cycles - t0 + 3) / 6));
        @(negedge clk_in);
        soft_rst_in = 1'b1;
        @(negedge clk_in);
        soft_rst_in = 1'b0;
        m_mid = 0;
        check_time(1);
        rd(rtctk_pkg::OFF_FRAC);
        chk("fraction", 8'(m_f), rd_v);
        rd(rtctk_pkg::OFF_TRIM);
        chk("trim", 8'h00, rd_v);
        rd(rtctk_pkg::OFF_ALARM);
        chk("alarm value", 8'h00, rd_v);
        $display("test soft reset done");
        rst_n_in = 1'b0;
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (5) @(negedge clk_in);
        por_check();
        $display("test power on reset done");
        test_done();
    end
endmodule
`default_nettype wire
